// file: src/usrt_pkg.sv
package usrt_pkg;
    localparam int          DIV_W        = 12;
    localparam logic [3:0]  ADDR_DATA    = 4'h0;
    localparam logic [3:0]  ADDR_CSA     = 4'h1;
    localparam logic [3:0]  ADDR_CSB     = 4'h2;
    localparam logic [3:0]  ADDR_CSC     = 4'h3;
    localparam logic [3:0]  ADDR_DIVL    = 4'h4;
    localparam logic [3:0]  ADDR_DIVH    = 4'h5;
    localparam logic [3:0]  ADDR_PWR     = 4'h6;
    // control_status_a fields
    localparam int          CSA_RXC      = 7;
    localparam int          CSA_TXC      = 6;
    localparam int          CSA_DRE      = 5;
    localparam int          CSA_FE       = 4;
    localparam int          CSA_DOR      = 3;
    localparam int          CSA_PE       = 2;
    localparam int          CSA_U2X      = 1;
    // control_status_b fields
    localparam int          CSB_RXEN     = 4;
    localparam int          CSB_TXEN     = 3;
    localparam int          CSB_RX9      = 1;
    localparam int          CSB_TX9      = 0;
    // control_status_c fields
    localparam int          CSC_SYNC     = 6;
    localparam int          CSC_PAR_EN   = 5;
    localparam int          CSC_PAR_ODD  = 4;
    localparam int          CSC_XCKDIR   = 1;
    localparam int          CSC_CPOL     = 0;
    localparam logic [7:0]  CSA_RESET    = 8'h20;
    localparam logic [7:0]  CSB_RESET    = 8'h00;
    localparam logic [7:0]  CSC_RESET    = 8'h00;
    localparam logic [7:0]  PWR_RESET    = 8'h01;
    localparam logic [4:0]  OVS_NORMAL   = 5'h10;
    localparam logic [4:0]  OVS_DOUBLE   = 5'h08;
    localparam logic [4:0]  OVS_SYNC     = 5'h02;
    localparam logic [3:0]  FRAME_BITS   = 4'ha;
    typedef enum logic [1:0] {USRT_ASYNC, USRT_ASYNC2X, USRT_MASTER, USRT_SLAVE} usrt_mode_t;
endpackage

// file: src/usrt_core.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - four clock modes: async normal, async double, sync master, sync slave.
// - sync mode select bit one selects synchronous operation.
// - sync: pin direction output is master, input is slave.
// - transfer clock pin used only in synchronous modes.
// - baud down-counter reloads at zero and on divisor low write.
// - one baud pulse per zero, rate clock over divisor plus one.
// - transmit divides baud pulses by 16, 8 or 2 per mode; slave mode steps on external clock edges.
// - receiver samples on baud pulses, 16, 8 or 2 per bit; slave mode samples on external clock edges.
// - divisor is twelve bits from high and low registers.
// - double speed gives 8 samples per bit instead of 16.
// - slave clock passes synchroniser then edge detector.
// - two-entry receive FIFO, each data read pops one entry.
// - frame, overrun and ninth bit stored with each character.
// - full FIFO leaves character in shift register until next start.
// - receiver flags frame, overrun and parity errors.
// - one transmit buffer ahead of shift register for back to back.
// - three interrupt sources: tx complete, data empty, rx complete.
// - polarity zero: change on rising, sample on falling; reversed otherwise in slave mode, not at the master pin.
module usrt_core
    import usrt_pkg::*;
(
    input  wire logic                      ref_clk,
    input  wire logic                      reset,
    input  wire logic [3:0]                addr,
    input  wire logic [7:0]                wdata,
    input  wire logic                      wr_stb,
    input  wire logic                      rd_stb,
    output logic      [7:0]                rdata,
    input  wire logic                      rxd_pin,
    output logic                           txd_pin,
    input  wire logic                      xck_in,
    output logic                           xck_out,
    output logic                           xck_oe_n,
    output logic                           irq_rx_complete,
    output logic                           irq_tx_complete,
    output logic                           irq_data_empty
);
    import usrt_pkg::*;

    logic [7:0] control_status_a, control_status_b, control_status_c, power_reduction_register;
    logic [3:0] baud_divisor_high;
    logic [7:0] baud_divisor_low;
    logic [DIV_W-1:0] baud_cnt;
    logic       xck_s1, xck_s2, xck_s3;
    logic [4:0] tx_pre;
    logic       tx_bitclk_lvl;
    logic [8:0] tx_buf;
    logic       tx_buf_full;
    logic [10:0] tx_shift;
    logic [3:0] tx_bits;
    logic       txc_flag;
    logic [4:0] rx_ph;
    logic [3:0] rx_bits;
    logic       rx_busy, rx_hold;
    logic [9:0] rx_shift;
    logic [11:0] fifo [2];
    logic       wr_ptr, rd_ptr;
    logic [1:0] fifo_cnt;
    logic       rxd_s1, rxd_s2;

    //////////////////////////////////////////////////////////////////////////
    // mode decode
    wire        enabled    = ~power_reduction_register[0];
    wire        sync_mode_select = control_status_c[CSC_SYNC];
    wire        transfer_clock_pin_direction = control_status_c[CSC_XCKDIR];
    wire        double_speed_bit = control_status_a[CSA_U2X];
    wire        sync_clock_polarity = control_status_c[CSC_CPOL];
    usrt_mode_t mode;
    assign mode = !sync_mode_select ? (double_speed_bit ? USRT_ASYNC2X : USRT_ASYNC)
                : (transfer_clock_pin_direction ? USRT_MASTER : USRT_SLAVE);
    wire [4:0]  ovs = (mode == USRT_ASYNC)   ? OVS_NORMAL
                    : (mode == USRT_ASYNC2X) ? OVS_DOUBLE : OVS_SYNC;
    wire [DIV_W-1:0] divisor = {baud_divisor_high, baud_divisor_low};

    //////////////////////////////////////////////////////////////////////////
    // baud generator
    wire        divl_wr    = wr_stb && addr == ADDR_DIVL;
    wire        baud_tick  = enabled && baud_cnt == '0;
    // a low byte write reloads with the byte being written
    wire [DIV_W-1:0] baud_reload = divl_wr ? {baud_divisor_high, wdata} : divisor;
    always_ff @(posedge ref_clk) begin
        if (reset || divl_wr || baud_cnt == '0)
            baud_cnt <= reset ? '0 : baud_reload;
        else
            baud_cnt <= baud_cnt - 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // external clock sync and edge detect
    always_ff @(posedge ref_clk) begin
        xck_s1 <= reset ? 1'b0 : xck_in;
        xck_s2 <= reset ? 1'b0 : xck_s1;
        xck_s3 <= reset ? 1'b0 : xck_s2;
        rxd_s1 <= reset ? 1'b1 : rxd_pin;
        rxd_s2 <= reset ? 1'b1 : rxd_s1;
    end
    wire        ext_rise   = xck_s2 & ~xck_s3;
    wire        ext_fall   = ~xck_s2 & xck_s3;

    //////////////////////////////////////////////////////////////////////////
    // transmit bit clock and master clock pin
    // >= so a mode change with a larger count cannot wrap through 31
    wire        tx_pre_end = baud_tick && tx_pre >= ovs - 5'd1;
    wire        mst_half   = baud_tick && tx_pre == 5'd0 && mode == USRT_MASTER;
    always_ff @(posedge ref_clk) begin
        if (reset || !enabled)
            tx_pre <= '0;
        else if (baud_tick)
            tx_pre <= tx_pre_end ? 5'd0 : tx_pre + 5'd1;
    end
    always_ff @(posedge ref_clk) begin
        if (reset || mode != USRT_MASTER)
            tx_bitclk_lvl <= 1'b0;
        else if (mst_half || tx_pre_end)
            tx_bitclk_lvl <= mst_half;
    end
    // sync edges: change edge and sample edge per polarity
    wire        mst_rise   = mst_half;
    wire        mst_fall   = tx_pre_end && mode == USRT_MASTER;
    wire        clk_rise   = (mode == USRT_SLAVE) ? ext_rise : mst_rise;
    wire        clk_fall   = (mode == USRT_SLAVE) ? ext_fall : mst_fall;
    wire        change_edge = sync_clock_polarity ? clk_fall : clk_rise;
    wire        sample_edge = sync_clock_polarity ? clk_rise : clk_fall;
    wire        tx_step    = sync_mode_select ? change_edge : tx_pre_end;
    assign xck_out  = tx_bitclk_lvl ^ sync_clock_polarity;
    assign xck_oe_n = ~(enabled && mode == USRT_MASTER);

    //////////////////////////////////////////////////////////////////////////
    // transmitter with one write buffer
    wire        data_wr    = wr_stb && addr == ADDR_DATA;
    wire        txen       = enabled && control_status_b[CSB_TXEN];
    wire        tx_idle    = tx_bits == '0;
    wire        tx_load    = txen && tx_buf_full && tx_step && (tx_idle || tx_bits == 4'd1);
    wire        tx_parity  = ^tx_buf[7:0] ^ control_status_c[CSC_PAR_ODD];
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tx_buf_full <= 1'b0;
            tx_buf      <= '0;
        end else if (data_wr && txen) begin
            tx_buf_full <= 1'b1;
            tx_buf      <= {control_status_b[CSB_TX9], wdata};
        end else if (tx_load) begin
            tx_buf_full <= 1'b0;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset || !txen) begin
            tx_shift <= '1;
            tx_bits  <= '0;
        end else if (tx_load) begin
            tx_shift <= {1'b1, control_status_c[CSC_PAR_EN] ? tx_parity : 1'b1, tx_buf[7:0], 1'b0};
            tx_bits  <= FRAME_BITS + 4'd1;
        end else if (tx_step && !tx_idle) begin
            tx_shift <= {1'b1, tx_shift[10:1]};
            tx_bits  <= tx_bits - 4'd1;
        end
    end
    assign txd_pin = tx_shift[0];
    wire        tx_done    = tx_step && tx_bits == 4'd1 && !tx_load;

    //////////////////////////////////////////////////////////////////////////
    // receiver
    wire        rxen       = enabled && control_status_b[CSB_RXEN];
    wire        fifo_full  = fifo_cnt == 2'd2;
    wire        rx_start   = rxen && !rx_busy && !rxd_s2 &&
                             (sync_mode_select ? sample_edge : baud_tick);
    wire        rx_sample  = rx_busy && (sync_mode_select ? sample_edge
                             : baud_tick && rx_ph == (ovs >> 1));
    wire        rx_par_en  = control_status_c[CSC_PAR_EN];
    // parity adds one sample before the stop bit
    wire        rx_last    = rx_sample &&
                             rx_bits == (rx_par_en ? FRAME_BITS : FRAME_BITS - 4'd1);
    // async start sample high again: noise, not a start bit
    wire        rx_false   = rx_sample && !sync_mode_select && rx_bits == '0 && rxd_s2;
    // data lsb sits at bit 2, or at bit 1 when a parity bit follows
    wire [7:0]  rx_byte    = rx_par_en ? rx_shift[8:1] : rx_shift[9:2];
    wire        rx_par_bit = rx_shift[9];
    wire        rx_par_bad = rx_par_en &&
                             (^rx_byte ^ control_status_c[CSC_PAR_ODD] ^ rx_par_bit);
    wire        rx_fe      = !rxd_s2;
    wire        push       = rx_hold && !fifo_full;
    wire        data_rd    = rd_stb && addr == ADDR_DATA && fifo_cnt != 2'd0;
    wire        rx_overrun = rx_last && rx_hold && fifo_full;
    always_ff @(posedge ref_clk) begin
        if (reset || !rxen) begin
            rx_busy <= 1'b0;
            rx_ph   <= '0;
            rx_bits <= '0;
        end else if (rx_start) begin
            rx_busy <= 1'b1;
            rx_ph   <= sync_mode_select ? 5'd0 : 5'd1;
            rx_bits <= sync_mode_select ? 4'd1 : 4'd0;
        end else if (rx_busy) begin
            if (baud_tick && !sync_mode_select)
                rx_ph <= (rx_ph == ovs - 5'd1) ? 5'd0 : rx_ph + 5'd1;
            if (rx_sample)
                rx_bits <= rx_bits + 4'd1;
            if (rx_last || rx_false)
                rx_busy <= 1'b0;
        end
    end
    // overrun when a start bit displaces the held third level
    wire        lost_held  = rx_start && rx_hold && fifo_full;
    logic       rx_err_fe, rx_err_pe, rx_err_dor, rx_lost;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rx_shift   <= '0;
            rx_hold    <= 1'b0;
            rx_err_fe  <= 1'b0;
            rx_err_pe  <= 1'b0;
            rx_err_dor <= 1'b0;
            rx_lost    <= 1'b0;
        end else begin
            if (rx_sample && !rx_last)
                rx_shift <= {rxd_s2, rx_shift[9:1]};
            // lost character reported with the one that displaced it
            if (lost_held)
                rx_lost <= 1'b1;
            else if (rx_last)
                rx_lost <= 1'b0;
            if (rx_last) begin
                rx_hold    <= 1'b1;
                rx_err_fe  <= rx_fe;
                rx_err_pe  <= rx_par_bad;
                rx_err_dor <= rx_overrun | rx_lost;
            end else if (push || (rx_start && rx_hold)) begin
                rx_hold <= 1'b0;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            wr_ptr   <= 1'b0;
            rd_ptr   <= 1'b0;
            fifo_cnt <= '0;
        end else begin
            if (push) begin
                fifo[wr_ptr] <= {rx_err_fe, rx_err_dor, rx_err_pe,
                                 rx_par_en & rx_par_bit, rx_byte};
                wr_ptr <= ~wr_ptr;
            end
            if (data_rd)
                rd_ptr <= ~rd_ptr;
            fifo_cnt <= fifo_cnt + {1'b0, push} - {1'b0, data_rd};
        end
    end
    wire [11:0] head = fifo[rd_ptr];
    wire        head_ok = fifo_cnt != 2'd0;

    //////////////////////////////////////////////////////////////////////////
    // registers
    wire        csa_wr     = wr_stb && addr == ADDR_CSA;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            control_status_a         <= CSA_RESET;
            control_status_b         <= CSB_RESET;
            control_status_c         <= CSC_RESET;
            power_reduction_register <= PWR_RESET;
            baud_divisor_low         <= '0;
            baud_divisor_high        <= '0;
            txc_flag                 <= 1'b0;
        end else begin
            if (csa_wr)
                control_status_a[CSA_U2X] <= wdata[CSA_U2X];
            if (wr_stb && addr == ADDR_CSB)
                control_status_b <= wdata;
            if (wr_stb && addr == ADDR_CSC)
                control_status_c <= wdata;
            if (wr_stb && addr == ADDR_PWR)
                power_reduction_register <= {7'h00, wdata[0]};
            if (divl_wr)
                baud_divisor_low <= wdata;
            if (wr_stb && addr == ADDR_DIVH)
                baud_divisor_high <= wdata[3:0];
            // set beats the write-one clear
            if (tx_done && !tx_buf_full)
                txc_flag <= 1'b1;
            else if (csa_wr && wdata[CSA_TXC])
                txc_flag <= 1'b0;
        end
    end
    wire [7:0]  csa_view = {head_ok, txc_flag, !tx_buf_full,
                            head_ok & head[11], head_ok & head[10], head_ok & head[9],
                            double_speed_bit, 1'b0};
    wire [7:0]  csb_view = {control_status_b[7:3], head_ok & head[8], control_status_b[1:0]};
    logic [7:0] next_rdata;
    always_comb begin
        unique case (addr)
            ADDR_DATA: next_rdata = head_ok ? head[7:0] : 8'h00;
            ADDR_CSA:  next_rdata = csa_view;
            ADDR_CSB:  next_rdata = csb_view;
            ADDR_CSC:  next_rdata = control_status_c;
            ADDR_DIVL: next_rdata = baud_divisor_low;
            ADDR_DIVH: next_rdata = {4'h0, baud_divisor_high};
            ADDR_PWR:  next_rdata = power_reduction_register;
            default:   next_rdata = 8'h00;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        rdata <= (reset || !rd_stb) ? 8'h00 : next_rdata;
    end
    assign irq_rx_complete = head_ok;
    assign irq_tx_complete = txc_flag;
    assign irq_data_empty  = txen && !tx_buf_full;

    //////////////////////////////////////////////////////////////////////////
    // assertions
    a_baud_reload: assert property (@(posedge ref_clk) disable iff (reset)
        divl_wr |=> baud_cnt == divisor)
        else $error("baud counter not reloaded on divisor low write");
    a_baud_tick_rate: assert property (@(posedge ref_clk) disable iff (reset)
        baud_cnt == 12'd1 && !divl_wr && enabled && !(wr_stb && addr == ADDR_PWR)
        |=> baud_tick)
        else $error("baud pulse missing at zero");
    a_pin_async_off: assert property (@(posedge ref_clk) disable iff (reset)
        !sync_mode_select |-> xck_oe_n)
        else $error("transfer clock pin driven in async mode");
    a_ovs_select: assert property (@(posedge ref_clk) disable iff (reset)
        !sync_mode_select && !double_speed_bit |-> ovs == 5'd16)
        else $error("wrong async divide");
    a_double_speed: assert property (@(posedge ref_clk) disable iff (reset)
        !sync_mode_select && double_speed_bit |-> ovs == 5'd8)
        else $error("double speed divide not eight");
    a_slave_edges: assert property (@(posedge ref_clk) disable iff (reset)
        (mode == USRT_SLAVE && $rose(xck_s2)) |-> clk_rise)
        else $error("slave edge not detected");
    a_fifo_pop: assert property (@(posedge ref_clk) disable iff (reset)
        data_rd && !push |=> fifo_cnt == $past(fifo_cnt) - 2'd1)
        else $error("read did not pop one entry");
    a_fifo_bound: assert property (@(posedge ref_clk) disable iff (reset)
        fifo_full && rx_hold && !data_rd && !rx_start |=> rx_hold)
        else $error("held character lost without start bit");
    a_false_start: assert property (@(posedge ref_clk) disable iff (reset)
        rx_false |=> !rx_busy)
        else $error("false start bit not dropped");
    a_txc_set: assert property (@(posedge ref_clk) disable iff (reset)
        tx_done && !tx_buf_full |=> txc_flag)
        else $error("tx complete not set");
    a_master_pin: assert property (@(posedge ref_clk) disable iff (reset)
        mode == USRT_MASTER && enabled |-> !xck_oe_n)
        else $error("master does not drive clock pin");
    c_push: cover property (@(posedge ref_clk) disable iff (reset) push);
    c_overrun: cover property (@(posedge ref_clk) disable iff (reset) rx_overrun || lost_held);
    c_backtoback: cover property (@(posedge ref_clk) disable iff (reset) tx_load && !tx_idle);
    c_slave_rx: cover property (@(posedge ref_clk) disable iff (reset)
        mode == USRT_SLAVE && rx_sample);
endmodule

// file: sim/usrt_remote.sv
`timescale 1ns/10ps
module usrt_remote (
    input  wire logic ref_clk,
    input  wire logic txd_pin,
    output logic      rxd_pin,
    output logic      xck_in
);
    initial begin
        rxd_pin = 1'b1;
        xck_in  = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // async frame onto the receive line, lsb first, line back to idle high
    task automatic send_async(input logic [7:0] data, input logic stop, input int bit_cyc);
        logic [9:0] frame;
        frame = {stop, data, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk);
            rxd_pin <= frame[i];
            repeat (bit_cyc - 1) @(posedge ref_clk);
        end
        @(posedge ref_clk);
        rxd_pin <= 1'b1;
        // one idle bit so a low stop bit cannot run into the next start
        repeat (bit_cyc) @(posedge ref_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // slave clocking: clock only runs inside the frame, rests low after it
    task automatic send_sync(input logic [7:0] data, input int half);
        logic [9:0] frame;
        frame = {1'b1, data, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge ref_clk);
            xck_in  <= 1'b1;
            rxd_pin <= frame[i];
            repeat (half) @(posedge ref_clk);
            xck_in  <= 1'b0;
            repeat (half - 1) @(posedge ref_clk);
        end
        @(posedge ref_clk);
        rxd_pin <= 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // start bit length gives the bit time, then mid-bit sampling
    task automatic recv_async(output logic [7:0] data, output int bit_cyc);
        int n;
        n = 0;
        @(negedge txd_pin);
        while (txd_pin === 1'b0) begin
            @(negedge ref_clk);
            n++;
        end
        bit_cyc = n - 1;
        repeat (bit_cyc / 2) @(negedge ref_clk);
        for (int i = 0; i < 8; i++) begin
            data[i] = txd_pin;
            repeat (bit_cyc) @(negedge ref_clk);
        end
    endtask
endmodule

// file: sim/testbench.sv
`timescale 1ns/10ps
module testbench;
    import usrt_pkg::*;
    localparam int DIV = 1;
    logic       ref_clk, reset, wr_stb, rd_stb, rxd_pin, txd_pin;
    logic       xck_in, xck_out, xck_oe_n;
    logic       irq_rx_complete, irq_tx_complete, irq_data_empty;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, got;
    int         error_cnt, samples_checked, bit_cyc;
    logic [7:0] rx_data [3] = '{8'h11, 8'h5a, 8'h33};
    logic       rx_stop [3] = '{1'b1, 1'b0, 1'b1};

    usrt_core uut (
        .ref_clk         (ref_clk),
        .reset           (reset),
        .addr            (addr),
        .wdata           (wdata),
        .wr_stb          (wr_stb),
        .rd_stb          (rd_stb),
        .rdata           (rdata),
        .rxd_pin         (rxd_pin),
        .txd_pin         (txd_pin),
        .xck_in          (xck_in),
        .xck_out         (xck_out),
        .xck_oe_n        (xck_oe_n),
        .irq_rx_complete (irq_rx_complete),
        .irq_tx_complete (irq_tx_complete),
        .irq_data_empty  (irq_data_empty)
    );
    usrt_remote remote (
        .ref_clk (ref_clk),
        .txd_pin (txd_pin),
        .rxd_pin (rxd_pin),
        .xck_in  (xck_in)
    );

    always #50 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr_stb <= 1'b1;
        addr   <= a;
        wdata  <= d;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        rd_stb <= 1'b1;
        addr   <= a;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        @(negedge ref_clk);
        d = rdata;
    endtask
    // one frame out: buffer fills at once, frame and bit time on the line
    task automatic tx_frame(input logic [7:0] d, input int exp_cyc);
        logic [7:0] seen;
        fork
            remote.recv_async(seen, bit_cyc);
            begin
                wr(ADDR_DATA, d);
                @(negedge ref_clk);
                check("data empty after write", irq_data_empty, 1'b0);
            end
        join
        check("tx byte", seen, d);
        check("tx bit time", bit_cyc, exp_cyc);
        repeat (2 * exp_cyc) @(negedge ref_clk);
        check("tx complete", irq_tx_complete, 1'b1);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (25000) @(posedge ref_clk);
        error_cnt++;
        stop_test();
    end
    initial begin
        ref_clk = 1'b0; reset = 1'b1; addr = 4'h0; wdata = 8'h00;
        wr_stb = 1'b0; rd_stb = 1'b0; error_cnt = 0; samples_checked = 0;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        rd(ADDR_CSA, got); check("csa reset", got, CSA_RESET);
        rd(ADDR_CSB, got); check("csb reset", got, CSB_RESET);
        rd(ADDR_CSC, got); check("csc reset", got, CSC_RESET);
        rd(ADDR_PWR, got); check("power gate reset", got, PWR_RESET);
        wr(4'h7, 8'hff);
        rd(4'h7, got); check("unmapped read", got, 8'h00);
        check("pin idle", {xck_oe_n, txd_pin, irq_data_empty}, 3'b110);
        wr(ADDR_PWR, 8'h00);
        wr(ADDR_DIVH, 8'h00);
        wr(ADDR_DIVL, 8'(DIV));
        wr(ADDR_CSB, 8'h18);
        @(negedge ref_clk);
        check("data empty enabled", irq_data_empty, 1'b1);
        tx_frame(8'ha5, int'(OVS_NORMAL) * (DIV + 1));
        wr(ADDR_CSA, 8'h42);
        @(negedge ref_clk);
        check("tx complete cleared", irq_tx_complete, 1'b0);
        tx_frame(8'hc3, int'(OVS_DOUBLE) * (DIV + 1));
        wr(ADDR_CSA, 8'h40);
        // three frames unread: two in the fifo, third held in the shifter
        for (int i = 0; i < 3; i++)
            remote.send_async(rx_data[i], rx_stop[i], int'(OVS_NORMAL) * (DIV + 1));
        check("rx complete", irq_rx_complete, 1'b1);
        for (int i = 0; i < 3; i++) begin
            rd(ADDR_CSA, got);
            check("frame error flag", got[CSA_FE], !rx_stop[i]);
            rd(ADDR_DATA, got);
            check("rx byte", got, rx_data[i]);
        end
        rd(ADDR_DATA, got); check("empty fifo read", got, 8'h00);
        check("rx drained", irq_rx_complete, 1'b0);
        wr(ADDR_CSC, 8'h42);
        repeat (4) @(negedge ref_clk);
        check("master drives pin", xck_oe_n, 1'b0);
        got[0] = xck_out;
        repeat (2) @(negedge ref_clk);
        check("master clock toggles", xck_out, !got[0]);
        wr(ADDR_CSC, 8'h40);
        repeat (4) @(negedge ref_clk);
        check("slave releases pin", xck_oe_n, 1'b1);
        remote.send_sync(8'h96, 4);
        repeat (8) @(negedge ref_clk);
        rd(ADDR_DATA, got); check("slave rx byte", got, 8'h96);
        wr(ADDR_CSC, 8'h00);
        repeat (4) @(negedge ref_clk);
        check("async pin unused", xck_oe_n, 1'b1);
        stop_test();
    end
endmodule
